// >>> src/value_acq.sv
/*
 * register value acquisition: polls configured value slots, issues one or
 * two register reads, reorders and decodes the answer bytes, scales them.
 * assumes a serial engine on the same clock that frames requests and hands
 * back only the data bytes of the answer, in received order.
 */
`timescale 1ns/1ps
module value_acq #(
    parameter int EXT_CH = acq_pkg::EXT_CH,
    parameter int SLOTS_PER_CH = acq_pkg::SLOTS_PER_CH
) (
    // clock and reset
    input logic pclk,
    input logic presetn,
    // apb slave
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // read request to the serial engine
    output logic req_valid,
    output acq_pkg::mb_req_t req,
    input logic req_ready,
    // answer data bytes from the serial engine
    input logic rsp_valid,
    input logic [7:0] rsp_byte,
    input logic rsp_error,
    // decoded values
    output logic result_valid,
    output acq_pkg::result_t result
);
    localparam int NSLOT = (EXT_CH + 1) * SLOTS_PER_CH;
    localparam logic [5:0] LAST_SLOT = 6'(NSLOT - 1);

    typedef enum logic [2:0] {S_IDLE, S_CHECK, S_ISSUE, S_COLLECT, S_DECODE, S_SCALE} state_t;
    state_t state;

    logic run, ext_en, ext_en_q, id_err, rsp_err;
    logic [7:0] base_id;
    logic [7:0] ext_id [EXT_CH];
    logic [EXT_CH-1:0] ext_inh;
    acq_pkg::slot_cfg_t cfg [NSLOT];
    logic [15:0] scale [NSLOT];
    logic [5:0] cur;
    logic [1:0] bcnt;
    logic [7:0] rx [4];
    logic [31:0] dec_val;

    // apb decode; no wait state, and every answer comes from a flop
    wire setup = psel & ~penable;
    wire wr = psel & penable & pready & pwrite;
    wire [5:0] a_slot = paddr[8:3];
    wire in_slot = paddr[11:9] == acq_pkg::OFS_SLOT[11:9] && 32'(a_slot) < NSLOT;
    wire in_ext = paddr[11:4] == acq_pkg::OFS_EXT_ID[11:4] && paddr[1:0] == 2'h0;
    wire [1:0] a_ext = paddr[3:2];
    wire hit_ctrl = paddr == acq_pkg::OFS_CTRL;
    wire hit_base = paddr == acq_pkg::OFS_BASE_ID;
    wire hit_stat = paddr == acq_pkg::OFS_STATUS;
    wire hit_res = paddr == acq_pkg::OFS_RESULT;
    wire mapped = in_slot | in_ext | hit_ctrl | hit_base | hit_stat | hit_res;
    wire [31:0] st_word = {18'h0_0000, cur, 5'h00, rsp_err, id_err, state != S_IDLE};
    wire [31:0] rd_mux =
        in_slot ? (paddr[2] ? {16'h0000, scale[a_slot]} : 32'(cfg[a_slot])) :
        in_ext ? {23'h00_0000, ext_inh[a_ext], ext_id[a_ext]} :
        hit_ctrl ? {30'h0000_0000, ext_en, run} :
        hit_base ? {24'h00_0000, base_id} :
        hit_stat ? st_word :
        hit_res ? result.value : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup;
            pslverr <= setup & ~mapped;
            prdata <= setup ? rd_mux : prdata;
        end
    end

    // control and base id
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run <= 1'b0;
            ext_en <= 1'b0;
            ext_en_q <= 1'b0;
            base_id <= acq_pkg::BASE_ID_RST;
        end else begin
            ext_en_q <= ext_en;
            if (wr && hit_ctrl) begin
                run <= pwdata[acq_pkg::CTRL_RUN];
                ext_en <= pwdata[acq_pkg::CTRL_EXT_EN];
            end
            if (wr && hit_base) begin
                base_id <= pwdata[7:0];
            end
        end
    end

    // extended channel ids: seeded from the base id when the option turns on
    wire ext_rise = ext_en & ~ext_en_q;
    genvar k;
    generate
        for (k = 0; k < EXT_CH; k++) begin : g_ext
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ext_id[k] <= acq_pkg::BASE_ID_RST;
                    ext_inh[k] <= 1'b1;
                end else if (ext_rise) begin
                    ext_id[k] <= base_id;
                    ext_inh[k] <= 1'b1;
                end else if (wr && in_ext && 32'(a_ext) == k) begin
                    ext_id[k] <= pwdata[7:0];
                    ext_inh[k] <= pwdata[acq_pkg::EXT_INHERIT];
                end
            end
        end
    endgenerate

    // slot configuration and scale store
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NSLOT; i++) begin
                cfg[i] <= '0;
                scale[i] <= acq_pkg::SCALE_RST;
            end
        end else if (wr && in_slot) begin
            if (paddr[2]) begin
                scale[a_slot] <= pwdata[15:0];
            end else begin
                cfg[a_slot] <= pwdata;
            end
        end
    end

    // current slot: channel, effective slave id, request shape
    acq_pkg::slot_cfg_t cc;
    assign cc = cfg[cur];
    wire [2:0] cur_ch = cur[5:3];
    wire [1:0] ext_ix = 2'(cur_ch - 3'h1);
    wire ch_live = cur_ch == 3'h0 || (ext_en && 32'(cur_ch) <= EXT_CH);
    // an inheriting channel reads the live base id, not a stale copy
    wire [7:0] ch_id = (cur_ch == 3'h0 || ext_inh[ext_ix]) ? base_id : ext_id[ext_ix];
    wire [7:0] eff_id = cc.own_id ? cc.id : ch_id;
    wire id_ok = eff_id >= acq_pkg::ID_MIN && eff_id <= acq_pkg::ID_MAX;
    wire slot_live = cc.use_en & ch_live;
    wire [1:0] need_regs = acq_pkg::is_wide(cc.dtype) ? 2'h2 : 2'h1;
    wire [1:0] last_byte = acq_pkg::is_wide(cc.dtype) ? 2'h3 : 2'h1;
    wire [5:0] next_cur = cur == LAST_SLOT ? 6'h00 : cur + 6'h01;

    // byte reassembly for every order
    wire swap = cc.order == acq_pkg::ORDER_DCBA || cc.order == acq_pkg::ORDER_BADC;
    wire [31:0] ord32 =
        cc.order == acq_pkg::ORDER_ABCD ? {rx[0], rx[1], rx[2], rx[3]} :
        cc.order == acq_pkg::ORDER_DCBA ? {rx[3], rx[2], rx[1], rx[0]} :
        cc.order == acq_pkg::ORDER_BADC ? {rx[1], rx[0], rx[3], rx[2]} :
        {rx[2], rx[3], rx[0], rx[1]};
    wire [15:0] w16 = swap ? {rx[1], rx[0]} : {rx[0], rx[1]};
    wire [7:0] b8 = swap ? rx[0] : rx[1];

    // float to signed integer, truncating toward zero and saturating
    function automatic logic [31:0] f2i(input logic [31:0] f);
        logic [7:0] e;
        logic [31:0] m;
        logic [31:0] mag;
        e = f[30:23];
        m = {8'h00, 1'b1, f[22:0]};
        if (e < acq_pkg::FLT_BIAS) begin
            mag = 32'h0000_0000;
        end else if (e > acq_pkg::FLT_MAX_EXP) begin
            mag = acq_pkg::FLT_SAT;
        end else if (e >= acq_pkg::FLT_UNIT_EXP) begin
            mag = m << (e - acq_pkg::FLT_UNIT_EXP);
        end else begin
            mag = m >> (acq_pkg::FLT_UNIT_EXP - e);
        end
        return f[31] ? 32'(-mag) : mag;
    endfunction

    // type interpretation
    wire [31:0] decoded =
        cc.dtype == acq_pkg::U8_TYPE ? {24'h00_0000, b8} :
        cc.dtype == acq_pkg::S8_TYPE ? {{24{b8[7]}}, b8} :
        cc.dtype == acq_pkg::U16_TYPE ? {16'h0000, w16} :
        cc.dtype == acq_pkg::S16_TYPE ? {{16{w16[15]}}, w16} :
        cc.dtype == acq_pkg::FLOAT32_TYPE ? f2i(ord32) :
        ord32;

    // scaling: unsigned values get a zero top bit so they stay positive
    wire signed [32:0] mul_a = {acq_pkg::is_signed(cc.dtype) & dec_val[31], dec_val};
    wire signed [15:0] mul_b = scale[cur];
    wire signed [48:0] prod = mul_a * mul_b;
    wire scale_off = scale[cur] == 16'h0000;

    // polling sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= S_IDLE;
            cur <= 6'h00;
            bcnt <= 2'h0;
            req_valid <= 1'b0;
            req <= '0;
            result_valid <= 1'b0;
            result <= '0;
            dec_val <= 32'h0000_0000;
            id_err <= 1'b0;
            rsp_err <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                rx[i] <= 8'h00;
            end
        end else begin
            result_valid <= 1'b0;
            // write one clears; a same-cycle event still sets
            if (wr && hit_stat && pwdata[acq_pkg::ST_ID_ERR]) begin
                id_err <= 1'b0;
            end
            if (wr && hit_stat && pwdata[acq_pkg::ST_RSP_ERR]) begin
                rsp_err <= 1'b0;
            end
            case (state)
                S_IDLE: begin
                    if (run) begin
                        state <= S_CHECK;
                    end
                end
                S_CHECK: begin
                    if (!run) begin
                        state <= S_IDLE;
                    end else if (slot_live && id_ok) begin
                        req_valid <= 1'b1;
                        req.slave_id <= eff_id;
                        req.func <= cc.input_reg ? acq_pkg::FUNC_INPUT
                                                 : acq_pkg::FUNC_HOLDING;
                        req.addr <= cc.addr;
                        req.count <= need_regs;
                        state <= S_ISSUE;
                    end else begin
                        if (slot_live) begin
                            id_err <= 1'b1;
                        end
                        cur <= next_cur;
                    end
                end
                S_ISSUE: begin
                    if (req_ready) begin
                        req_valid <= 1'b0;
                        bcnt <= 2'h0;
                        state <= S_COLLECT;
                    end
                end
                S_COLLECT: begin
                    if (rsp_error) begin
                        rsp_err <= 1'b1;
                        cur <= next_cur;
                        state <= S_CHECK;
                    end else if (rsp_valid) begin
                        rx[bcnt] <= rsp_byte;
                        bcnt <= bcnt + 2'h1;
                        if (bcnt == last_byte) begin
                            state <= S_DECODE;
                        end
                    end
                end
                S_DECODE: begin
                    dec_val <= decoded;
                    state <= S_SCALE;
                end
                S_SCALE: begin
                    result_valid <= 1'b1;
                    result.slot <= cur;
                    result.value <= scale_off ? dec_val : prod[31:0];
                    cur <= next_cur;
                    state <= S_CHECK;
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_check_go;
        state == S_CHECK && run && slot_live && id_ok;
    endsequence
    sequence s_req_up;
        req_valid && state == S_ISSUE;
    endsequence

    a_func_class: assert property (s_check_go |=> s_req_up ##0
        req.func == ($past(cc.input_reg) ? acq_pkg::FUNC_INPUT : acq_pkg::FUNC_HOLDING))
        else $error("request function does not match register class");
    a_addr_passed: assert property (s_check_go |=> req.addr == $past(cc.addr))
        else $error("request address differs from slot address");
    a_count_wide: assert property (s_check_go and acq_pkg::is_wide(cc.dtype)
        |=> req.count == 2'h2)
        else $error("32-bit slot did not request two registers");
    a_count_narrow: assert property (s_check_go and !acq_pkg::is_wide(cc.dtype)
        |=> req.count == 2'h1)
        else $error("narrow slot did not request one register");
    a_id_range: assert property ($rose(req_valid)
        |-> req.slave_id >= acq_pkg::ID_MIN && req.slave_id <= acq_pkg::ID_MAX)
        else $error("request issued with slave id out of range");
    // a cleared run parks the scan without stepping, so only a running scan must skip
    a_skip_unused: assert property (state == S_CHECK && run && !slot_live
        |=> !req_valid && cur == $past(next_cur))
        else $error("disabled slot was polled");
    a_ext_seed: assert property ($rose(ext_en) |=> ##1 ext_inh == '1
        && ext_id[0] == $past(base_id, 2))
        else $error("extended id not seeded from base id");
    a_scale_off: assert property (state == S_SCALE && scale_off
        |=> result_valid && result.value == $past(dec_val))
        else $error("zero scale altered the value");
    a_s8_sign: assert property (state == S_DECODE && cc.dtype == acq_pkg::S8_TYPE
        |=> dec_val[31:8] == {24{dec_val[7]}})
        else $error("signed 8-bit value not sign extended");
endmodule

// >>> src/acq_pkg.sv
/*
 * shared constants and carriers for the register value acquisition block:
 * register map, type and byte order codes, float decode figures, slot layout.
 * assumes a 12-bit apb byte address and a 32-bit data bus.
 */
package acq_pkg;
    // channel shape: one base channel plus extended ones
    localparam int SLOTS_PER_CH = 8;
    localparam int EXT_CH = 4;

    // register byte offsets
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_BASE_ID = 12'h004;
    localparam logic [11:0] OFS_EXT_ID = 12'h010;
    localparam logic [11:0] OFS_STATUS = 12'h020;
    localparam logic [11:0] OFS_RESULT = 12'h024;
    localparam logic [11:0] OFS_SLOT = 12'h200;

    // control, status and ext id bit positions
    localparam int CTRL_RUN = 0;
    localparam int CTRL_EXT_EN = 1;
    localparam int ST_BUSY = 0;
    localparam int ST_ID_ERR = 1;
    localparam int ST_RSP_ERR = 2;
    localparam int ST_SLOT_POS = 8;
    localparam int EXT_INHERIT = 8;

    // reset values
    localparam logic [7:0] BASE_ID_RST = 8'h01;
    localparam logic [15:0] SCALE_RST = 16'h0000;

    // data type codes
    localparam logic [2:0] U8_TYPE = 3'h0;
    localparam logic [2:0] S8_TYPE = 3'h1;
    localparam logic [2:0] U16_TYPE = 3'h2;
    localparam logic [2:0] S16_TYPE = 3'h3;
    localparam logic [2:0] U32_TYPE = 3'h4;
    localparam logic [2:0] S32_TYPE = 3'h5;
    localparam logic [2:0] FLOAT32_TYPE = 3'h6;

    // byte order codes
    localparam logic [1:0] ORDER_ABCD = 2'h0;
    localparam logic [1:0] ORDER_DCBA = 2'h1;
    localparam logic [1:0] ORDER_BADC = 2'h2;
    localparam logic [1:0] ORDER_CDAB = 2'h3;

    // read function codes and slave id window
    localparam logic [7:0] FUNC_HOLDING = 8'h03;
    localparam logic [7:0] FUNC_INPUT = 8'h04;
    localparam logic [7:0] ID_MIN = 8'h01;
    localparam logic [7:0] ID_MAX = 8'hf7;

    // single precision figures
    localparam logic [7:0] FLT_BIAS = 8'h7f;
    localparam logic [7:0] FLT_UNIT_EXP = 8'h96;
    localparam logic [7:0] FLT_MAX_EXP = 8'h9d;
    localparam logic [31:0] FLT_SAT = 32'h7fff_ffff;

    // one slot configuration word
    typedef struct packed {
        logic [7:0] id;
        logic own_id;
        logic [1:0] order;
        logic [2:0] dtype;
        logic input_reg;
        logic use_en;
        logic [15:0] addr;
    } slot_cfg_t;

    // read request handed to the serial engine
    typedef struct packed {
        logic [7:0] slave_id;
        logic [7:0] func;
        logic [15:0] addr;
        logic [1:0] count;
    } mb_req_t;

    // decoded and scaled value
    typedef struct packed {
        logic [5:0] slot;
        logic [31:0] value;
    } result_t;

    // 32-bit types need two registers
    function automatic logic is_wide(input logic [2:0] dtype);
        return dtype == U32_TYPE || dtype == S32_TYPE || dtype == FLOAT32_TYPE;
    endfunction

    function automatic logic is_signed(input logic [2:0] dtype);
        return dtype == S8_TYPE || dtype == S16_TYPE || dtype == S32_TYPE
            || dtype == FLOAT32_TYPE;
    endfunction
endpackage

// >>> tb/slave_model.sv
/*
 * sensor stand-in on the far side of the request link: takes one read
 * request, stalls, then returns the bytes of data most significant first.
 * assumes the bench changes data, delay and abort only between transfers.
 */
`timescale 1ns/1ps
module slave_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // request link
    input wire logic req_valid,
    input wire acq_pkg::mb_req_t req,
    output logic req_ready,
    // answer bytes
    output logic rsp_valid,
    output logic [7:0] rsp_byte,
    output logic rsp_error,
    // bench controls
    input wire logic [31:0] data,
    input wire logic [1:0] delay,
    input wire logic abort
);
    logic busy;
    logic [1:0] cnt;
    logic [1:0] idx;
    logic [2:0] left;

    // one read at a time; the byte line wanders while idle so stale data never looks valid
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {busy, cnt, idx, left, req_ready, rsp_valid, rsp_error} <= '0;
            rsp_byte <= 8'h00;
        end else begin
            rsp_valid <= 1'b0;
            rsp_error <= 1'b0;
            rsp_byte <= rsp_byte + 8'h5b;
            if (req_valid && req_ready) begin
                req_ready <= 1'b0;
                busy <= 1'b1;
                cnt <= 2'h0;
                idx <= 2'h0;
                left <= {req.count, 1'b0};
            end else if (!busy) begin
                // a slow sensor holds off acceptance for delay cycles
                req_ready <= req_valid && cnt == delay;
                if (req_valid && cnt != delay) begin
                    cnt <= cnt + 2'h1;
                end
            end else if (cnt != delay) begin
                cnt <= cnt + 2'h1;
            end else if (abort) begin
                rsp_error <= 1'b1;
                busy <= 1'b0;
            end else begin
                cnt <= 2'h0;
                rsp_valid <= 1'b1;
                rsp_byte <= data[8 * (3 - int'(idx)) +: 8];
                idx <= idx + 2'h1;
                left <= left - 3'h1;
                busy <= left != 3'h1;
            end
        end
    end
endmodule

// >>> tb/tb_top.sv
/*
 * bench for the value acquisition block: apb master tasks, a sensor model
 * on the request link, random and corner decode runs, slave id checks.
 * assumes one-cycle apb answers and that only one slot is enabled per run.
 */
`timescale 1ns/1ps
module tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd, ctrl, data;
    logic pready, pslverr, req_valid, req_ready, rsp_valid, rsp_error, result_valid, err;
    logic [7:0] rsp_byte;
    logic [1:0] delay = 2'h0;
    logic abort = 1'b0;
    acq_pkg::mb_req_t req, got_req;
    acq_pkg::result_t result, got_res;
    int n_fail = 0;
    int samples_checked = 0;
    int n_req = 0;
    int n_res = 0;

    always #5 pclk = ~pclk;

    value_acq dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_byte(rsp_byte), .rsp_error(rsp_error),
        .result_valid(result_valid), .result(result));

    slave_model partner (.pclk(pclk), .presetn(presetn), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_byte(rsp_byte),
        .rsp_error(rsp_error), .data(data), .delay(delay), .abort(abort));

    // log every accepted request and every result
    always @(posedge pclk) begin
        if (req_valid && req_ready) begin
            got_req <= req;
            n_req <= n_req + 1;
        end
        if (result_valid === 1'b1) begin
            got_res <= result;
            n_res <= n_res + 1;
        end
    end

    task automatic print_verdict;
        if (n_fail == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one apb transfer; waits for pready with a bound, a hang ends the run
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        chk("pready", 32'h1, 32'(pready));
        if (pready !== 1'b1) print_verdict();
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask

    task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp,
                          input logic exp_err);
        apb(1'b0, a, 32'h0000_0000);
        chk(name, exp, rd);
        chk("pslverr", 32'(exp_err), 32'(err));
    endtask

    // let the scan poll, count requests and results, then stop it
    task automatic run_one(input logic [5:0] slot, input logic exp_req, input logic exp_res,
                           input logic [7:0] id);
        int r0, s0, i;
        r0 = n_req;
        s0 = n_res;
        apb(1'b1, acq_pkg::OFS_CTRL, ctrl | 32'h0000_0001);
        for (i = 0; i < 300 && n_req == r0; i++) @(posedge pclk);
        chk("request count", 32'(exp_req), 32'(n_req - r0));
        if (exp_req && n_req == r0) print_verdict();
        if (exp_req) chk("slave id", 32'(id), 32'(got_req.slave_id));
        for (i = 0; i < 300 && n_res == s0 && exp_res; i++) @(posedge pclk);
        apb(1'b1, acq_pkg::OFS_CTRL, ctrl);
        repeat (60) @(posedge pclk);
        chk("result count", 32'(exp_res), 32'(n_res - s0));
        if (exp_res && n_res == s0) print_verdict();
        if (exp_res) chk("result slot", 32'(slot), 32'(got_res.slot));
    endtask

    // reorder, decode and scale by hand
    function automatic logic [31:0] expect_val(input logic [2:0] dt, input logic [1:0] od,
                                               input logic [31:0] d, input logic [15:0] sc);
        logic [7:0] b0, b1, b2, b3;
        logic [31:0] w, v, m;
        logic [15:0] h;
        logic sel;
        int e;
        {b0, b1, b2, b3} = d;
        w = od == acq_pkg::ORDER_DCBA ? {b3, b2, b1, b0} : od == acq_pkg::ORDER_BADC ?
            {b1, b0, b3, b2} : od == acq_pkg::ORDER_CDAB ? {b2, b3, b0, b1} : d;
        sel = od[0] ^ od[1];
        h = sel ? {b1, b0} : {b0, b1};
        e = int'(w[30:23]);
        m = {8'h00, 1'b1, w[22:0]};
        m = e < 127 ? 32'h0000_0000 : e > 157 ? 32'h7fff_ffff : e >= 150 ? m << (e - 150)
            : m >> (150 - e);
        case (dt)
            acq_pkg::U8_TYPE: v = {24'h00_0000, sel ? b0 : b1};
            acq_pkg::S8_TYPE: v = sel ? {{24{b0[7]}}, b0} : {{24{b1[7]}}, b1};
            acq_pkg::U16_TYPE: v = {16'h0000, h};
            acq_pkg::S16_TYPE: v = {{16{h[15]}}, h};
            acq_pkg::FLOAT32_TYPE: v = w[31] ? -m : m;
            default: v = w;
        endcase
        return sc == 16'h0000 ? v : v * {{16{sc[15]}}, sc};
    endfunction

    initial begin
        acq_pkg::slot_cfg_t cfg;
        logic [15:0] sc;
        int dt, od, i;
        void'($urandom(32'h8378_9ef4));
        ctrl = 32'h0000_0000;
        data = 32'h0000_0000;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk("ctrl", acq_pkg::OFS_CTRL, 32'h0000_0000, 1'b0);
        rd_chk("base id", acq_pkg::OFS_BASE_ID, 32'h0000_0001, 1'b0);
        rd_chk("ext id", acq_pkg::OFS_EXT_ID, 32'h0000_0101, 1'b0);
        rd_chk("scale", acq_pkg::OFS_SLOT + 12'h004, 32'h0000_0000, 1'b0);
        rd_chk("unmapped", 12'h100, 32'h0000_0000, 1'b1);
        // every type with every byte order; first order carries the corner values
        for (dt = 0; dt < 7; dt++) begin
            for (od = 0; od < 4; od++) begin
                data <= od == 0 ? (dt == 6 ? 32'hc228_0000 : 32'h80ff_7f01) : $urandom;
                delay <= 2'($urandom);
                cfg = '0;
                cfg.use_en = 1'b1;
                cfg.dtype = 3'(dt);
                cfg.order = 2'(od);
                cfg.input_reg = 1'($urandom);
                cfg.addr = od == 0 ? 16'hffff : od == 1 ? 16'h0000 : 16'($urandom);
                sc = od[0] ? 16'($urandom) : 16'h0000;
                apb(1'b1, acq_pkg::OFS_SLOT, cfg);
                apb(1'b1, acq_pkg::OFS_SLOT + 12'h004, {16'h0000, sc});
                run_one(6'h00, 1'b1, 1'b1, 8'h01);
                chk("func", cfg.input_reg ? 32'h4 : 32'h3, 32'(got_req.func));
                chk("addr", 32'(cfg.addr), 32'(got_req.addr));
                chk("count", dt >= 4 ? 32'h2 : 32'h1, 32'(got_req.count));
                if (sc == 16'h0000) chk("value", expect_val(cfg.dtype, cfg.order, data, sc),
                    got_res.value);
                else chk("scaled", expect_val(cfg.dtype, cfg.order, data, sc),
                    got_res.value);
            end
        end
        // own slave id at and beyond the legal window
        cfg.own_id = 1'b1;
        for (i = 0; i < 3; i++) begin
            cfg.id = i == 0 ? 8'h00 : 8'(8'hf6 + i);
            apb(1'b1, acq_pkg::OFS_SLOT, cfg);
            run_one(6'h00, i == 1, i == 1, cfg.id);
            apb(1'b0, acq_pkg::OFS_STATUS, 32'h0000_0000);
            chk("id error", 32'(i != 1), 32'(rd[acq_pkg::ST_ID_ERR]));
            apb(1'b1, acq_pkg::OFS_STATUS, 32'h0000_0002);
        end
        cfg.use_en = 1'b0;
        apb(1'b1, acq_pkg::OFS_SLOT, cfg);
        run_one(6'h00, 1'b0, 1'b0, 8'h00);
        // extended channel: off, seeded, inheriting, overridden, own id
        cfg.use_en = 1'b1;
        cfg.own_id = 1'b0;
        apb(1'b1, acq_pkg::OFS_SLOT + 12'h040, cfg);
        run_one(6'h08, 1'b0, 1'b0, 8'h00);
        apb(1'b1, acq_pkg::OFS_BASE_ID, 32'h0000_0005);
        ctrl = 32'h0000_0002;
        apb(1'b1, acq_pkg::OFS_CTRL, ctrl);
        rd_chk("ext seeded", acq_pkg::OFS_EXT_ID, 32'h0000_0105, 1'b0);
        run_one(6'h08, 1'b1, 1'b1, 8'h05);
        apb(1'b1, acq_pkg::OFS_BASE_ID, 32'h0000_0009);
        run_one(6'h08, 1'b1, 1'b1, 8'h09);
        apb(1'b1, acq_pkg::OFS_EXT_ID, 32'h0000_0021);
        run_one(6'h08, 1'b1, 1'b1, 8'h21);
        cfg.own_id = 1'b1;
        cfg.id = 8'h4d;
        apb(1'b1, acq_pkg::OFS_SLOT + 12'h040, cfg);
        run_one(6'h08, 1'b1, 1'b1, 8'h4d);
        // sensor aborts: no value, error flag raised
        abort <= 1'b1;
        run_one(6'h08, 1'b1, 1'b0, 8'h4d);
        abort <= 1'b0;
        // the slot field shows where the scan parked, which depends on stop timing
        apb(1'b0, acq_pkg::OFS_STATUS, 32'h0000_0000);
        chk("status", 32'h0000_0004, rd & ~(32'h0000_003f << acq_pkg::ST_SLOT_POS));
        chk("pslverr", 32'h0000_0000, 32'(err));
        cfg.use_en = 1'b0;
        apb(1'b1, acq_pkg::OFS_SLOT + 12'h040, cfg);
        cfg.use_en = 1'b1;
        cfg.own_id = 1'b0;
        apb(1'b1, acq_pkg::OFS_SLOT + 12'h138, cfg);
        run_one(6'h27, 1'b1, 1'b1, 8'h09);
        print_verdict();
    end
endmodule
